// ### rtl/efm_pkg.sv
package efm_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    typedef logic [6:0] efm_idx_t;
    typedef logic [8:0] efm_addr_t;

    localparam efm_idx_t IDX_IO_CTRL  = 7'h01;
    localparam efm_idx_t IDX_RX_CFG   = 7'h11;
    localparam efm_idx_t IDX_INT_STAT = 7'h14;
    localparam efm_idx_t IDX_INT_MASK = 7'h15;
    localparam efm_idx_t IDX_ERR_HI   = 7'h52;
    localparam efm_idx_t IDX_ERR_LO   = 7'h53;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned RESYNC_BIT   = 0;
    localparam int unsigned WIN_SEL_BIT  = 7;
    localparam int unsigned CFG_LOF_BIT  = 6;
    localparam int unsigned CFG_OOF_BIT  = 5;
    localparam int unsigned INT_OOF_BIT  = 3;
    localparam int unsigned INT_LOF_BIT  = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic        WIN_SEL_RST  = 1'b0;
    localparam logic [7:0]  INT_MASK_RST = 8'h00;
    localparam logic [15:0] ERR_CNT_RST  = 16'h0000;
    localparam logic [15:0] ERR_CNT_MAX  = 16'hffff;

    // ----------------------------------------------------------------
    // Frame timing, in line bits and frames
    // ----------------------------------------------------------------
    localparam logic [10:0] FRAME_LAST    = 11'h5ff;
    localparam logic [10:0] FAS_LAST      = 11'h009;
    localparam logic [10:0] FAS_NEXT      = 11'h00a;
    localparam logic [9:0]  FAS_WORD      = 10'h3d0;
    localparam logic [2:0]  BAD_RUN_LIMIT = 3'h4;
    localparam logic [4:0]  OOF_WIN_LONG  = 5'h18;
    localparam logic [4:0]  OOF_WIN_SHORT = 5'h08;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SEARCH = 2'h0,
        ST_INF    = 2'h1,
        ST_OOF    = 2'h3,
        ST_LOF    = 2'h2
    } efm_state_e;

    typedef struct packed {
        logic valid;
        logic data;
    } efm_bit_s;

    typedef struct packed {
        logic        read;
        logic        write;
        efm_addr_t   address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } efm_avs_req_s;

    typedef struct packed {
        logic clk_meta;
        logic clk_sync;
        logic clk_prev;
        logic dat_meta;
        logic dat_sync;
        efm_bit_s bit_out;
    } efm_samp_s;

    typedef struct packed {
        efm_state_e  st;
        logic [10:0] bit_pos;
        logic [9:0]  shift;
        logic [2:0]  bad_run;
        logic [4:0]  oof_frames;
        logic [15:0] err_cnt;
        logic        win_sel;
        logic        oof;
        logic        lof;
        logic [7:0]  int_stat;
        logic [7:0]  int_mask;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdata;
    } efm_state_s;

    localparam efm_samp_s SAMP_RST = '0;

    localparam efm_state_s STATE_RST = '{
        st: ST_SEARCH, bit_pos: 11'h000, shift: 10'h000,
        bad_run: 3'h0, oof_frames: 5'h00, err_cnt: ERR_CNT_RST,
        win_sel: WIN_SEL_RST, oof: 1'b1, lof: 1'b1,
        int_stat: 8'h00, int_mask: INT_MASK_RST, irq: 1'b0,
        waitreq: 1'b1, rdata: 32'h0000_0000};

    // Byte address match against a register index
    function automatic logic efm_hit(efm_addr_t addr, efm_idx_t idx);
        return addr == {idx, 2'h0};
    endfunction

endpackage

// ### rtl/efm_line_sampler.sv
`timescale 1ns/1ps
`default_nettype none

// Brings the receive line clock and data into core_clk and marks each
// rising line-clock edge with a one-cycle bit strobe.
module efm_line_sampler (
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               rx_line_clk,
    input  wire logic               rx_line_data,
    output var  efm_pkg::efm_bit_s  line_bit
);

    efm_pkg::efm_samp_s s;
    efm_pkg::efm_samp_s n;

    // ----------------------------------------------------------------
    // Synchronisers and edge finder
    // ----------------------------------------------------------------
    // Clock and data share the same depth so the data bit stays aligned
    always_comb begin
        n                = s;
        n.clk_meta       = rx_line_clk;
        n.clk_sync       = s.clk_meta;
        n.clk_prev       = s.clk_sync;
        n.dat_meta       = rx_line_data;
        n.dat_sync       = s.dat_meta;
        n.bit_out.valid  = s.clk_sync & ~s.clk_prev;
        n.bit_out.data   = s.dat_sync;
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= efm_pkg::SAMP_RST;
        end else begin
            s <= n;
        end
    end

    assign line_bit = s.bit_out;

endmodule

`default_nettype wire

// ### rtl/efm_frame_maint.sv
// Function
// - While in frame, every frame's alignment word is checked at its slot.
// - Out-of-frame is declared only after four consecutive bad words.
// - Each bad alignment word bumps a 16-bit error counter at 0x52/0x53, which holds at 0xffff.
// - Both counter bytes are read-only and clear to zero when read.
// - Writing one to bit 0 of 0x01 forces the alignment search state.
// - A forced resync drives both indicator pins high.
// - A forced resync raises both framing change interrupts.
// - A forced resync sets both framing status bits at 0x11.
// - Pins read in-frame 00, out-of-frame 01, loss 11, never loss only.
// - Out-of-frame turns to loss after 24 frames, or 8 with select set.
// - Loss of frame drops sync and goes straight to the search state.
// - Entering in-frame raises both interrupts and clears pins and bits.
// - Framing change events set bits 3 and 2 at 0x14, cleared by read.
`timescale 1ns/1ps
`default_nettype none

module efm_frame_maint (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        rx_line_clk,
    input  wire logic        rx_line_data,
    input  wire logic [8:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    output logic             out_of_frame_indicator,
    output logic             loss_of_frame_indicator,
    output logic             irq
);

    efm_pkg::efm_state_s   s;
    efm_pkg::efm_state_s   n;
    efm_pkg::efm_bit_s     line_bit;
    efm_pkg::efm_avs_req_s req;

    logic        service;
    logic        rd_hit_lo;
    logic        rd_hit_hi;
    logic        resync;
    logic        check;
    logic        fas_ok;
    logic        err_evt;
    logic        oof_evt;
    logic        lof_evt;
    logic [4:0]  oof_limit;
    logic [15:0] cnt;
    logic [7:0]  cfg_rd;

    // ----------------------------------------------------------------
    // Line front end
    // ----------------------------------------------------------------
    efm_line_sampler u_sampler (
        .core_clk     (core_clk),
        .reset        (reset),
        .rx_line_clk  (rx_line_clk),
        .rx_line_data (rx_line_data),
        .line_bit     (line_bit)
    );

    // Bus request bundle
    assign req = '{read: read, write: write, address: address,
                   writedata: writedata, byteenable: byteenable};

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        n         = s;
        err_evt   = 1'b0;
        oof_evt   = 1'b0;
        lof_evt   = 1'b0;
        // One access per request; waitrequest drops for one cycle only
        service   = (req.read | req.write) & s.waitreq;
        rd_hit_lo = service & req.read &
                    efm_pkg::efm_hit(req.address, efm_pkg::IDX_ERR_LO);
        rd_hit_hi = service & req.read &
                    efm_pkg::efm_hit(req.address, efm_pkg::IDX_ERR_HI);
        resync    = service & req.write & req.byteenable[0] &
                    req.writedata[efm_pkg::RESYNC_BIT] &
                    efm_pkg::efm_hit(req.address,
                                     efm_pkg::IDX_IO_CTRL);
        oof_limit = s.win_sel ? efm_pkg::OOF_WIN_SHORT
                              : efm_pkg::OOF_WIN_LONG;
        fas_ok    = {s.shift[8:0], line_bit.data} == efm_pkg::FAS_WORD;
        check     = line_bit.valid &
                    (s.bit_pos == efm_pkg::FAS_LAST);

        // Frame position and alignment window shift
        if (line_bit.valid) begin
            n.shift   = {s.shift[8:0], line_bit.data};
            n.bit_pos = (s.bit_pos == efm_pkg::FRAME_LAST)
                        ? 11'h000 : s.bit_pos + 11'h001;
        end

        // Framing state machine
        unique case (s.st)
            efm_pkg::ST_SEARCH: begin
                // Minimal search: first alignment word found locks
                if (line_bit.valid && fas_ok) begin
                    n.bit_pos = efm_pkg::FAS_NEXT;
                    n.st      = efm_pkg::ST_INF;
                    n.oof     = 1'b0;
                    n.lof     = 1'b0;
                    n.bad_run = 3'h0;
                    oof_evt   = 1'b1;
                    lof_evt   = 1'b1;
                end
            end
            efm_pkg::ST_INF: begin
                if (check && fas_ok) begin
                    n.bad_run = 3'h0;
                end else if (check) begin
                    err_evt = 1'b1;
                    if (s.bad_run == efm_pkg::BAD_RUN_LIMIT - 3'h1) begin
                        n.st         = efm_pkg::ST_OOF;
                        n.oof        = 1'b1;
                        n.oof_frames = 5'h00;
                        oof_evt      = 1'b1;
                    end else begin
                        n.bad_run = s.bad_run + 3'h1;
                    end
                end
            end
            efm_pkg::ST_OOF: begin
                // Old alignment is still used while hunting for it
                if (check && fas_ok) begin
                    n.st      = efm_pkg::ST_INF;
                    n.oof     = 1'b0;
                    n.lof     = 1'b0;
                    n.bad_run = 3'h0;
                    oof_evt   = 1'b1;
                    lof_evt   = 1'b1;
                end else if (check) begin
                    err_evt = 1'b1;
                    if (s.oof_frames == oof_limit - 5'h01) begin
                        n.st    = efm_pkg::ST_LOF;
                        n.lof   = 1'b1;
                        lof_evt = 1'b1;
                    end else begin
                        n.oof_frames = s.oof_frames + 5'h01;
                    end
                end
            end
            efm_pkg::ST_LOF: begin
                n.st = efm_pkg::ST_SEARCH;
            end
        endcase

        // Forced resync overrides the line's framing outcome this cycle, not its error count
        if (resync) begin
            n.st  = efm_pkg::ST_SEARCH;
            n.oof = 1'b1;
            n.lof = 1'b1;
            oof_evt = 1'b1;
            lof_evt = 1'b1;
        end

        // Error counter: read clears its byte, a new error still counts
        cnt = s.err_cnt;
        if (rd_hit_hi) begin
            cnt[15:8] = 8'h00;
        end
        if (rd_hit_lo) begin
            cnt[7:0] = 8'h00;
        end
        if (err_evt && cnt != efm_pkg::ERR_CNT_MAX) begin
            cnt = cnt + 16'h0001;
        end
        n.err_cnt = cnt;

        // Sticky events: read or write-one clears, a new event wins
        if (service && req.read &&
            efm_pkg::efm_hit(req.address, efm_pkg::IDX_INT_STAT)) begin
            n.int_stat = 8'h00;
        end
        if (service && req.write && req.byteenable[0] &&
            efm_pkg::efm_hit(req.address, efm_pkg::IDX_INT_STAT)) begin
            n.int_stat = s.int_stat & ~req.writedata[7:0];
        end
        n.int_stat[efm_pkg::INT_OOF_BIT] =
            n.int_stat[efm_pkg::INT_OOF_BIT] | oof_evt;
        n.int_stat[efm_pkg::INT_LOF_BIT] =
            n.int_stat[efm_pkg::INT_LOF_BIT] | lof_evt;

        // Register writes
        if (service && req.write && req.byteenable[0]) begin
            if (efm_pkg::efm_hit(req.address, efm_pkg::IDX_RX_CFG)) begin
                n.win_sel = req.writedata[efm_pkg::WIN_SEL_BIT];
            end
            if (efm_pkg::efm_hit(req.address, efm_pkg::IDX_INT_MASK)) begin
                n.int_mask = req.writedata[7:0];
            end
        end
        n.int_stat = n.int_stat & 8'h0c;
        n.int_mask = n.int_mask & 8'h0c;
        n.irq      = |(n.int_stat & n.int_mask);

        // Read data; unmapped addresses read zero
        cfg_rd                       = 8'h00;
        cfg_rd[efm_pkg::WIN_SEL_BIT] = s.win_sel;
        cfg_rd[efm_pkg::CFG_LOF_BIT] = s.lof;
        cfg_rd[efm_pkg::CFG_OOF_BIT] = s.oof;
        n.waitreq = ~service;
        if (service && req.read) begin
            n.rdata = 32'h0000_0000;
            if (efm_pkg::efm_hit(req.address, efm_pkg::IDX_RX_CFG)) begin
                n.rdata[7:0] = cfg_rd;
            end
            if (efm_pkg::efm_hit(req.address, efm_pkg::IDX_INT_STAT)) begin
                n.rdata[7:0] = s.int_stat;
            end
            if (efm_pkg::efm_hit(req.address, efm_pkg::IDX_INT_MASK)) begin
                n.rdata[7:0] = s.int_mask;
            end
            if (rd_hit_hi) begin
                n.rdata[7:0] = s.err_cnt[15:8];
            end
            if (rd_hit_lo) begin
                n.rdata[7:0] = s.err_cnt[7:0];
            end
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s <= efm_pkg::STATE_RST;
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from the state register
    // ----------------------------------------------------------------
    assign readdata                = s.rdata;
    assign waitrequest             = s.waitreq;
    assign out_of_frame_indicator  = s.oof;
    assign loss_of_frame_indicator = s.lof;
    assign irq                     = s.irq;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_oof_after_four: assert property (
        (s.st == efm_pkg::ST_INF && s.bad_run == 3'h3 && check &&
         !fas_ok && !resync) |=> (s.st == efm_pkg::ST_OOF) &&
        out_of_frame_indicator && !loss_of_frame_indicator)
        else $error("four bad words did not declare out of frame");

    a_no_early_oof: assert property (
        (s.st == efm_pkg::ST_INF && s.bad_run < 3'h3 && check &&
         !resync) |=> s.st == efm_pkg::ST_INF)
        else $error("left in-frame before four bad words");

    a_frame_check: assert property (
        (s.st == efm_pkg::ST_INF && line_bit.valid &&
         s.bit_pos == efm_pkg::FRAME_LAST) |=> s.bit_pos == 11'h000)
        else $error("frame position did not wrap");

    a_err_count_inc: assert property (
        (err_evt && !service && s.err_cnt != 16'hffff)
        |=> s.err_cnt == $past(s.err_cnt) + 16'h0001)
        else $error("alignment error not counted");

    a_count_rd_clear: assert property (
        (rd_hit_lo && !err_evt) |=> s.err_cnt[7:0] == 8'h00 &&
        !waitrequest)
        else $error("counter low byte not cleared on read");

    a_resync_search: assert property (
        resync |=> s.st == efm_pkg::ST_SEARCH && out_of_frame_indicator
        && loss_of_frame_indicator && s.int_stat[3:2] == 2'h3)
        else $error("forced resync did not restart search");

    a_resync_once: assert property (
        resync |=> !resync)
        else $error("one write gave two resync commands");

    a_pin_code: assert property (
        !(loss_of_frame_indicator && !out_of_frame_indicator))
        else $error("invalid indicator pin code");

    a_oof_window: assert property (
        (s.st == efm_pkg::ST_OOF && check && !fas_ok && !resync &&
         s.oof_frames == oof_limit - 5'h01)
        |=> s.st == efm_pkg::ST_LOF ##1 s.st == efm_pkg::ST_SEARCH)
        else $error("out of frame window did not end in loss");

    a_inf_entry: assert property (
        (s.st != efm_pkg::ST_INF ##1 s.st == efm_pkg::ST_INF)
        |-> !out_of_frame_indicator && !loss_of_frame_indicator &&
        s.int_stat[3:2] == 2'h3)
        else $error("in-frame entry effects missing");

    a_bus_answer: assert property (
        ((read || write) && waitrequest) |=> !waitrequest ##1
        waitrequest)
        else $error("bus answer not one cycle");

    c_resync: cover property (resync ##1 s.st == efm_pkg::ST_SEARCH);
    c_enter_oof: cover property (s.st == efm_pkg::ST_INF ##1
                                 s.st == efm_pkg::ST_OOF);
    c_enter_lof: cover property (s.st == efm_pkg::ST_LOF);
    c_irq: cover property (irq && rd_hit_lo);

endmodule

`default_nettype wire

// ### testbench/efm_line_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Line interface stand-in
// ----------------------------------------------------------------
// The line clock stands still between frames, so the bench decides
// when each frame goes out and the framer simply waits in between.
module efm_line_model (
    output logic rx_line_clk,
    output logic rx_line_data
);
    localparam int FRAME_BITS = 1536;
    localparam int HALF_NS    = 80;

    initial begin
        rx_line_clk  = 1'b0;
        rx_line_data = 1'b0;
    end

    // Word first, first bit sent first; an all-zero payload can never
    // pass for the alignment word while the framer is searching
    task automatic send_frame(input logic [9:0] word);
        // Keep every line edge clear of the core clock's sampling edge
        #5;
        for (int i = 0; i < FRAME_BITS; i++) begin
            rx_line_data = (i < 10) ? word[9 - i] : 1'b0;
            #HALF_NS rx_line_clk = 1'b1;
            #HALF_NS rx_line_clk = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// ### testbench/efm_frame_maint_tb.sv
`timescale 1ns/1ps
`default_nettype none

module efm_frame_maint_tb;
    localparam int TIMEOUT = 230000;
    logic        core_clk;
    logic        reset;
    logic        rx_line_clk;
    logic        rx_line_data;
    logic [8:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        oof_pin;
    logic        lof_pin;
    logic        irq;
    logic [7:0]  rd;
    int          n_mismatch = 0;
    int          compares = 0;
    int          cycles = 0;

    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    efm_frame_maint u_efm_frame_maint (
        .core_clk(core_clk), .reset(reset),
        .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .out_of_frame_indicator(oof_pin),
        .loss_of_frame_indicator(lof_pin), .irq(irq));

    efm_line_model u_efm_line_model (
        .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon access; held until waitrequest is seen low
    task automatic bus(input logic wr, input efm_pkg::efm_idx_t idx,
                       input logic [7:0] d);
        @(posedge core_clk);
        address   <= {idx, 2'h0};
        writedata <= {24'h000000, d};
        write     <= wr;
        read      <= ~wr;
        // Only the run's own timeout ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    task automatic rd_chk(input efm_pkg::efm_idx_t idx,
                          input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask

    // Sample off the clock edge so registered pins have settled
    task automatic pins_chk(input logic [7:0] exp, input logic irq_exp);
        @(negedge core_clk);
        check({6'h00, lof_pin, oof_pin}, exp);
        check({7'h00, irq}, {7'h00, irq_exp});
    endtask

    task automatic bad_frames(input int n, input logic [7:0] pins,
                              input logic irq_exp);
        for (int i = 0; i < n; i++) begin
            u_efm_line_model.send_frame(10'h000);
            pins_chk(pins, irq_exp);
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        pins_chk(8'h03, 1'b0);
        rd_chk(efm_pkg::IDX_RX_CFG, 8'h60);
        rd_chk(efm_pkg::IDX_ERR_HI, 8'h00);
        rd_chk(7'h30, 8'h00);
        bus(1'b1, efm_pkg::IDX_INT_MASK, 8'h0c);
        rd_chk(efm_pkg::IDX_INT_MASK, 8'h0c);
    endtask

    task automatic t_lock();
        u_efm_line_model.send_frame(efm_pkg::FAS_WORD);
        pins_chk(8'h00, 1'b1);
        rd_chk(efm_pkg::IDX_INT_STAT, 8'h0c);
        rd_chk(efm_pkg::IDX_INT_STAT, 8'h00);
        pins_chk(8'h00, 1'b0);
        rd_chk(efm_pkg::IDX_RX_CFG, 8'h00);
    endtask

    // Resync from in-frame, then one clean relock proves a single search
    task automatic t_resync();
        bus(1'b1, efm_pkg::IDX_IO_CTRL, 8'h01);
        pins_chk(8'h03, 1'b1);
        rd_chk(efm_pkg::IDX_INT_STAT, 8'h0c);
        rd_chk(efm_pkg::IDX_RX_CFG, 8'h60);
        rd_chk(efm_pkg::IDX_IO_CTRL, 8'h00);
        u_efm_line_model.send_frame(efm_pkg::FAS_WORD);
        pins_chk(8'h00, 1'b1);
        rd_chk(efm_pkg::IDX_INT_STAT, 8'h0c);
    endtask

    // Three misses are tolerated, the fourth declares out-of-frame
    task automatic t_errors();
        bus(1'b1, efm_pkg::IDX_RX_CFG, 8'h80);
        rd_chk(efm_pkg::IDX_RX_CFG, 8'h80);
        bad_frames(3, 8'h00, 1'b0);
        rd_chk(efm_pkg::IDX_ERR_HI, 8'h00);
        rd_chk(efm_pkg::IDX_ERR_LO, 8'h03);
        rd_chk(efm_pkg::IDX_ERR_LO, 8'h00);
        bus(1'b1, efm_pkg::IDX_ERR_LO, 8'hff);
        rd_chk(efm_pkg::IDX_ERR_LO, 8'h00);
        bad_frames(1, 8'h01, 1'b1);
        rd_chk(efm_pkg::IDX_INT_STAT, 8'h08);
        rd_chk(efm_pkg::IDX_RX_CFG, 8'ha0);
        rd_chk(efm_pkg::IDX_ERR_LO, 8'h01);
    endtask

    // Short window: the eighth failed check turns to loss and search
    task automatic t_lof();
        bad_frames(7, 8'h01, 1'b0);
        bus(1'b1, efm_pkg::IDX_INT_MASK, 8'h08);
        u_efm_line_model.send_frame(10'h000);
        pins_chk(8'h03, 1'b0);
        rd_chk(efm_pkg::IDX_INT_STAT, 8'h04);
        rd_chk(efm_pkg::IDX_RX_CFG, 8'he0);
        rd_chk(efm_pkg::IDX_ERR_LO, 8'h08);
    endtask

    // ----------------------------------------------------------------
    // Verdict and run control
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("Mismatches %0d, compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Fourteen frames of 12288 cycles each plus bus traffic
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == TIMEOUT) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        reset      = 1'b1;
        read       = 1'b0;
        write      = 1'b0;
        address    = 9'h000;
        writedata  = 32'h0000_0000;
        byteenable = 4'h1;
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_lock();
        t_resync();
        t_errors();
        t_lof();
        end_sim();
    end
endmodule

`default_nettype wire
